/* File: rtl/ioc_regs.sv */
// Purpose: configuration and control registers of the i/o channel controller
// Assumes: processor loads/stores arrive as one-cycle requests on sys_clk
// Notes:   every answer comes one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module ioc_regs
	import ioc_pkg::*;
#(
	parameter bit HAS_64BIT = 1'b1
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [3:0]  req_index,
	input  wire logic        req_word,
	input  wire logic [31:0] req_wdata,
	output logic             rsp_valid,
	output logic [31:0]      rsp_rdata,
	output logic             rsp_fault,
	output logic [3:0]       rsp_fault_code,
	input  wire logic        bus_timeout,
	input  wire logic [3:0]  arb_pins,
	input  wire logic        burst_pin,
	input  wire logic        card_channel_ready_pin,
	input  wire logic [1:0]  sdr_pins,
	input  wire logic        ext_irq_pin,
	input  wire logic        arb_req,
	input  wire logic [3:0]  arb_level,
	output logic             irq_out,
	output logic             arb_start,
	output logic [15:0]      slot_reset,
	input  wire logic        bm_valid,
	input  wire logic        bm_io,
	input  wire logic [31:0] bm_addr,
	output logic             bm_done,
	output logic             bm_to_system,
	output logic             master_enable,
	output logic             mode64,
	output logic [31:0]      tce_addr_w0,
	output logic [31:0]      tce_addr_w1
);
	ioc_bus_if bus ();

	// settled copies of the asynchronous bus pins
	ioc_pin_sync u_sync (
		.sys_clk                (sys_clk),
		.rst                    (rst),
		.arb_pins               (arb_pins),
		.burst_pin              (burst_pin),
		.card_channel_ready_pin (card_channel_ready_pin),
		.sdr_pins               (sdr_pins),
		.ext_irq_pin            (ext_irq_pin),
		.bus                    (bus.src)
	);

	logic        me_reg;
	logic        me_next;
	logic        mode_reg;
	logic        mode_next;
	logic [31:0] pers_reg;
	logic [31:0] pers_next;
	logic [7:0]  snap_reg;
	logic [7:0]  snap_next;
	logic        tflag_reg;
	logic        tflag_next;
	logic [31:0] tce0_reg;
	logic [31:0] tce1_reg;
	logic [15:0] slot_ctl_reg;
	logic [15:0] slot_ctl_next;
	logic [15:0] slot_rst_reg;
	logic [31:0] map_reg;
	logic        irq_reg;
	logic        arb_reg;
	logic        rsp_valid_reg;
	logic        rsp_fault_reg;
	logic [31:0] rsp_rdata_reg;
	logic [31:0] rd_mux;
	logic        unmapped;

	// request classification
	wire logic w0_missing = ~HAS_64BIT & (req_index == IDX_TCE_W0);
	wire logic bad_req    = req_valid & (~req_word | w0_missing | unmapped);
	wire logic wr         = req_valid & req_write & ~bad_req;
	wire logic wr_cfg     = wr & (req_index == IDX_CFG);
	wire logic wr_pers    = wr & (req_index == IDX_PERS);
	wire logic wr_tce0    = wr & (req_index == IDX_TCE_W0);
	wire logic wr_tce1    = wr & (req_index == IDX_TCE_W1);
	wire logic wr_slot    = wr & (req_index == IDX_SLOT);
	wire logic wr_map     = wr & (req_index == IDX_MAP);
	wire logic wr_misc    = wr & (req_index == IDX_MISC);

	// capability fields are constants, so stores cannot reach them
	wire logic [31:0] cfg_word = {me_reg, 23'h00_0000, mode_reg, CFG_MAX_TCE,
		CFG_DMA_CHANS};
	wire logic [7:0]  bus_sample = {bus.sdr, bus.card_channel_ready,
		bus.burst, bus.arb};

	// configuration: the timeout clear beats a software set in the same cycle
	assign me_next   = bus_timeout ? 1'b0 : (wr_cfg ? req_wdata[CFG_ME_BIT] : me_reg);
	// a 32-bit part keeps the bit at zero and drops the store
	assign mode_next = (wr_cfg & HAS_64BIT) ? req_wdata[CFG_MODE_BIT] : mode_reg;

	// only implemented personalization bits take store data
	assign pers_next = wr_pers ? (req_wdata & PERS_IMPL_MASK) : pers_reg;

	// first timeout freezes the snapshot; set wins over a clear
	assign snap_next  = (bus_timeout & ~tflag_reg) ? bus_sample : snap_reg;
	assign tflag_next = bus_timeout |
		(tflag_reg & ~(wr_misc & ~req_wdata[MISC_TIMEOUT_BIT]));

	// slot control: timeout drops every slot back into reset
	assign slot_ctl_next = bus_timeout ? 16'h0000 :
		(wr_slot ? req_wdata[31:SLOT_LSB] : slot_ctl_reg);

	// load data selection
	always_comb
	begin
		unmapped = 1'b0;
		rd_mux   = ZERO_WORD;
		if (req_index == IDX_CFG)
			rd_mux = cfg_word;
		else if (req_index == IDX_PERS)
			rd_mux = pers_reg;
		else if (req_index == IDX_SNAP)
			rd_mux = tflag_reg ? {24'h00_0000, snap_reg} : ZERO_WORD;
		else if (req_index == IDX_TCE_W0)
			rd_mux = tce0_reg;
		else if (req_index == IDX_TCE_W1)
			rd_mux = tce1_reg;
		else if (req_index == IDX_SLOT)
			rd_mux = {slot_ctl_reg, 16'h0000};
		else if (req_index == IDX_MAP)
			rd_mux = map_reg;
		else if (req_index == IDX_MISC)
			rd_mux = {1'b0, tflag_reg, 30'h0000_0000};
		else
			unmapped = 1'b1;
	end

	// control state; startup values are the documented constants
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			me_reg       <= 1'b0;
			mode_reg     <= HAS_64BIT;
			pers_reg     <= PERS_RESET;
			snap_reg     <= 8'h00;
			tflag_reg    <= 1'b0;
			slot_ctl_reg <= 16'h0000;
			slot_rst_reg <= 16'hffff;
		end
		else
		begin
			me_reg       <= me_next;
			mode_reg     <= mode_next;
			pers_reg     <= pers_next;
			snap_reg     <= snap_next;
			tflag_reg    <= tflag_next;
			slot_ctl_reg <= slot_ctl_next;
			slot_rst_reg <= ~slot_ctl_next;
		end
	end

	// table address and bus map; firmware loads these before enabling
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tce0_reg <= ZERO_WORD;
			tce1_reg <= ZERO_WORD;
			map_reg  <= ZERO_WORD;
		end
		else
		begin
			if (wr_tce0)
				tce0_reg <= req_wdata;
			if (wr_tce1)
				tce1_reg <= req_wdata;
			if (wr_map)
				map_reg <= req_wdata;
		end
	end

	// gates and answers; level 15 is not an arbitration level
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			irq_reg       <= 1'b0;
			arb_reg       <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_fault_reg <= 1'b0;
			rsp_rdata_reg <= ZERO_WORD;
		end
		else
		begin
			irq_reg       <= me_reg & bus.ext_irq;
			arb_reg       <= me_reg & arb_req & (arb_level < ARB_LEVELS);
			rsp_valid_reg <= req_valid;
			rsp_fault_reg <= bad_req;
			rsp_rdata_reg <= (req_valid & ~req_write & ~bad_req) ? rd_mux : ZERO_WORD;
		end
	end

	ioc_bm_route u_route (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.bm_valid     (bm_valid),
		.bm_io        (bm_io),
		.bm_addr      (bm_addr),
		.map_word     (map_reg),
		.bm_done      (bm_done),
		.bm_to_system (bm_to_system)
	);

	assign irq_out        = irq_reg;
	assign arb_start      = arb_reg;
	assign slot_reset     = slot_rst_reg;
	assign master_enable  = me_reg;
	assign mode64         = mode_reg;
	assign tce_addr_w0    = tce0_reg;
	assign tce_addr_w1    = tce1_reg;
	assign rsp_valid      = rsp_valid_reg;
	assign rsp_fault      = rsp_fault_reg;
	assign rsp_rdata      = rsp_rdata_reg;
	assign rsp_fault_code = rsp_fault_reg ? FAULT_INVALID_OP : FAULT_NONE;

	// checks on the register behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_irq_block;
		!me_reg |=> !irq_out;
	endproperty
	a_irq_block: assert property (p_irq_block) else $error("interrupt passed while disabled");

	property p_arb_block;
		!me_reg |=> !arb_start;
	endproperty
	a_arb_block: assert property (p_arb_block) else $error("arbitration while disabled");

	property p_me_set_by_sw;
		$rose(me_reg) |-> $past(wr_cfg) && !$past(bus_timeout);
	endproperty
	a_me_set_by_sw: assert property (p_me_set_by_sw) else $error("enable set by hardware");

	property p_timeout_edge;
		bus_timeout |=> !me_reg && slot_ctl_reg == 16'h0000 && slot_reset == 16'hffff
			&& tflag_reg;
	endproperty
	a_timeout_edge: assert property (p_timeout_edge) else $error("timeout effects not aligned");

	property p_mode_change;
		$changed(mode_reg) |-> HAS_64BIT && $past(wr_cfg);
	endproperty
	a_mode_change: assert property (p_mode_change) else $error("mode bit changed wrongly");

	property p_cfg_ro_read;
		req_valid && !req_write && req_word && req_index == IDX_CFG
			|=> rsp_rdata[6:0] == {CFG_MAX_TCE, CFG_DMA_CHANS} && rsp_rdata[30:8] == 23'h0;
	endproperty
	a_cfg_ro_read: assert property (p_cfg_ro_read) else $error("config fields wrong");

	property p_arb_level;
		arb_start |-> $past(arb_level) != 4'hf && $past(arb_req);
	endproperty
	a_arb_level: assert property (p_arb_level) else $error("bad arbitration level");

	property p_pers_zero;
		req_valid && !req_write && req_word && req_index == IDX_PERS
			|=> (rsp_rdata & ~PERS_IMPL_MASK) == ZERO_WORD;
	endproperty
	a_pers_zero: assert property (p_pers_zero) else $error("unimplemented bits nonzero");

	property p_snap_capture;
		bus_timeout && !tflag_reg |=> snap_reg == $past(bus_sample);
	endproperty
	a_snap_capture: assert property (p_snap_capture) else $error("snapshot not captured");

	property p_snap_hold;
		tflag_reg ##1 tflag_reg |-> $stable(snap_reg);
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot overwritten");

	property p_snap_read;
		req_valid && !req_write && req_word && req_index == IDX_SNAP
			|=> rsp_rdata[31:8] == 24'h0 && (rsp_rdata[7:0] == ($past(tflag_reg) ?
			$past(snap_reg) : 8'h00));
	endproperty
	a_snap_read: assert property (p_snap_read) else $error("snapshot read wrong");

	property p_word0_fault;
		req_valid && req_index == IDX_TCE_W0 && !HAS_64BIT
			|=> rsp_valid && rsp_fault && rsp_fault_code == FAULT_INVALID_OP;
	endproperty
	a_word0_fault: assert property (p_word0_fault) else $error("word 0 access not faulted");

	property p_narrow_fault;
		req_valid && !req_word |=> rsp_valid && rsp_fault && rsp_fault_code == FAULT_INVALID_OP;
	endproperty
	a_narrow_fault: assert property (p_narrow_fault) else $error("narrow access accepted");

	property p_slot_out;
		wr_slot && !bus_timeout |=> slot_reset == ~$past(req_wdata[31:SLOT_LSB]);
	endproperty
	a_slot_out: assert property (p_slot_out) else $error("slot reset not following store");
endmodule
`default_nettype wire

/* File: rtl/ioc_pkg.sv */
// Purpose: shared constants for the i/o channel controller register bank
// Assumes: word-wide register port indexed by register number
// Notes:   bit 0 of every documented field is the most significant bit ([31])
package ioc_pkg;
	// register indices on the load/store port
	localparam logic [3:0] IDX_CFG     = 4'h0;
	localparam logic [3:0] IDX_PERS    = 4'h1;
	localparam logic [3:0] IDX_SNAP    = 4'h2;
	localparam logic [3:0] IDX_TCE_W0  = 4'h3;
	localparam logic [3:0] IDX_TCE_W1  = 4'h4;
	localparam logic [3:0] IDX_SLOT    = 4'h5;
	localparam logic [3:0] IDX_MAP     = 4'h6;
	localparam logic [3:0] IDX_MISC    = 4'h7;

	// configuration register layout
	localparam int CFG_ME_BIT   = 31;
	localparam int CFG_MODE_BIT = 7;
	localparam logic [2:0] CFG_MAX_TCE   = 3'h3;
	localparam logic [3:0] CFG_DMA_CHANS = 4'h8;
	localparam logic [3:0] ARB_LEVELS    = 4'hf;

	// personalization: implemented bits and value after reset
	localparam logic [31:0] PERS_IMPL_MASK = 32'h0000_ffff;
	localparam logic [31:0] PERS_RESET     = 32'h0000_0000;

	// misc interrupt status: timeout flag position
	localparam int MISC_TIMEOUT_BIT = 30;

	// snapshot field positions (bits 0..23 of the register read as zero)
	localparam int SNAP_ARB_LSB   = 0;
	localparam int SNAP_BURST     = 4;
	localparam int SNAP_READY     = 5;
	localparam int SNAP_SDR_LSB   = 6;

	// slot reset: implemented slots sit in the top bits
	localparam int SLOT_COUNT = 16;
	localparam int SLOT_LSB   = 32 - SLOT_COUNT;

	// reset values and fault codes
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
	localparam logic [3:0]  FAULT_NONE = 4'h0;
	localparam logic [3:0]  FAULT_INVALID_OP = 4'h1;
endpackage

/* File: rtl/ioc_bus_if.sv */
// Purpose: carries synchronised bus pin levels to the register bank
// Assumes: single sys_clk domain on both sides
// Notes:   levels only, no handshake
`timescale 1ns/1ps
`default_nettype none
interface ioc_bus_if;
	logic [3:0] arb;
	logic       burst;
	logic       card_channel_ready;
	logic [1:0] sdr;
	logic       ext_irq;
	modport src (output arb, output burst, output card_channel_ready, output sdr, output ext_irq);
	modport dst (input arb, input burst, input card_channel_ready, input sdr, input ext_irq);
endinterface
`default_nettype wire

/* File: rtl/ioc_pin_sync.sv */
// Purpose: two-stage synchroniser for the sampled bus pins
// Assumes: pins are asynchronous to sys_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ioc_pin_sync
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [3:0] arb_pins,
	input  wire logic       burst_pin,
	input  wire logic       card_channel_ready_pin,
	input  wire logic [1:0] sdr_pins,
	input  wire logic       ext_irq_pin,
	ioc_bus_if.src          bus
);
	localparam int W = 9;
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// two flops per pin; metastability settles in the first
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= {ext_irq_pin, sdr_pins, card_channel_ready_pin, burst_pin, arb_pins};
			sync_reg <= meta_reg;
		end
	end

	// fan the settled levels out
	assign bus.arb                = sync_reg[3:0];
	assign bus.burst              = sync_reg[4];
	assign bus.card_channel_ready = sync_reg[5];
	assign bus.sdr                = sync_reg[7:6];
	assign bus.ext_irq            = sync_reg[8];
endmodule
`default_nettype wire

/* File: rtl/ioc_bm_route.sv */
// Purpose: routes bus master memory accesses to system memory or bus
// Assumes: map word uses bit 0 as msb
// Notes:   decision is registered, one cycle after bm_valid
`timescale 1ns/1ps
`default_nettype none
module ioc_bm_route
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        bm_valid,
	input  wire logic        bm_io,
	input  wire logic [31:0] bm_addr,
	input  wire logic [31:0] map_word,
	output logic             bm_done,
	output logic             bm_to_system
);
	// fine 1 MB blocks below 16 MB, one 240 MB block, then 256 MB blocks
	function automatic logic [4:0] map_index(input logic [31:0] a);
		if (a[31:28] != 4'h0)
			map_index = {1'b1, a[31:28]} + 5'h0;
		else if (a[27:24] != 4'h0)
			map_index = 5'h10;
		else
			map_index = {1'b0, a[23:20]};
	endfunction

	wire logic [4:0] idx      = map_index(bm_addr);
	wire logic       map_bit  = map_word[5'd31 - idx];
	// i/o space never goes to system memory whatever the map says
	wire logic       to_sys   = map_bit & ~bm_io;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			bm_done      <= 1'b0;
			bm_to_system <= 1'b0;
		end
		else
		begin
			bm_done      <= bm_valid;
			bm_to_system <= bm_valid & to_sys;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/ioc_cpu_model.sv */
// Purpose: processor side of the register port, issuing i/o loads and stores
// Assumes: answer is registered on the taking edge and read 1 ns after it
// Notes:   released index and data lines are inverted so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module ioc_cpu_model
(
	input  wire logic        sys_clk,
	output logic             req_valid,
	output logic             req_write,
	output logic [3:0]       req_index,
	output logic             req_word,
	output logic [31:0]      req_wdata,
	input  wire logic        rsp_valid,
	input  wire logic [31:0] rsp_rdata,
	input  wire logic        rsp_fault,
	input  wire logic [3:0]  rsp_fault_code
);
	logic [31:0] got_data;
	logic        got_fault;
	logic [3:0]  got_code;
	logic        got_ok;

	// idle levels at time zero
	initial
	begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_index = 4'h0;
		req_word  = 1'b1;
		req_wdata = 32'h0000_0000;
	end

	// drive after an edge, hold through the taking edge, sample once its answer settles
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic wd, input logic [31:0] dat);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_index <= idx;
		req_word  <= wd;
		req_wdata <= dat;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		req_index <= ~idx;
		req_wdata <= ~dat;
		#1;
		got_ok    = rsp_valid;
		got_data  = rsp_rdata;
		got_fault = rsp_fault;
		got_code  = rsp_fault_code;
	endtask
endmodule
`default_nettype wire

/* File: testbench/io_channel_config_regs_bench.sv */
// Purpose: self-checking bench for the register bank
// Assumes: 64-bit and 32-bit parts side by side, slot hold shortened to a few cycles
// Notes:   random values from a fixed seed, corner cases mixed in
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module io_channel_config_regs_bench;
	import ioc_pkg::*;
	localparam int LIMIT = 6000;
	localparam int SLOT_HOLD = 8;
	localparam logic [31:0] CORNER [6] = '{32'h0000_0000, 32'h00ff_ffff, 32'h0100_0000,
		32'h0fff_ffff, 32'h1000_0000, 32'hffff_ffff};
	logic sys_clk = 1'b0, rst = 1'b1, bus_timeout = 1'b0, burst_pin = 1'b0;
	logic card_channel_ready_pin = 1'b0, ext_irq_pin = 1'b0, arb_req = 1'b0;
	logic bm_valid = 1'b0, bm_io = 1'b0;
	logic [3:0] arb_pins = 4'h0, arb_level = 4'h0;
	logic [1:0] sdr_pins = 2'h0;
	logic [31:0] bm_addr = 32'h0000_0000;
	logic req_valid, req_write, req_word, rsp_valid, rsp_fault, irq_out, arb_start;
	logic bm_done, bm_to_system, master_enable, mode64;
	logic [3:0] req_index, rsp_fault_code;
	logic [31:0] req_wdata, rsp_rdata, tce_addr_w0, tce_addr_w1, r, d, e, a;
	logic [15:0] slot_reset;
	logic rsp32_valid, rsp32_fault, mode32;
	logic [3:0] rsp32_code;
	int miscompares = 0, cmp_count = 0, cyc = 0;

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	ioc_cpu_model cpu (.sys_clk(sys_clk), .req_valid(req_valid), .req_write(req_write),
		.req_index(req_index), .req_word(req_word), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_fault(rsp_fault),
		.rsp_fault_code(rsp_fault_code));

	ioc_regs #(.HAS_64BIT(1'b1)) dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
		.req_write(req_write), .req_index(req_index), .req_word(req_word),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_fault(rsp_fault), .rsp_fault_code(rsp_fault_code), .bus_timeout(bus_timeout),
		.arb_pins(arb_pins), .burst_pin(burst_pin),
		.card_channel_ready_pin(card_channel_ready_pin), .sdr_pins(sdr_pins),
		.ext_irq_pin(ext_irq_pin), .arb_req(arb_req), .arb_level(arb_level),
		.irq_out(irq_out), .arb_start(arb_start), .slot_reset(slot_reset),
		.bm_valid(bm_valid), .bm_io(bm_io), .bm_addr(bm_addr), .bm_done(bm_done),
		.bm_to_system(bm_to_system), .master_enable(master_enable), .mode64(mode64),
		.tce_addr_w0(tce_addr_w0), .tce_addr_w1(tce_addr_w1));

	// a part without 64-bit mode sees the same traffic; its valid and fault answers and mode bit are watched, its load data is not
	ioc_regs #(.HAS_64BIT(1'b0)) dut32 (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
		.req_write(req_write), .req_index(req_index), .req_word(req_word),
		.req_wdata(req_wdata), .rsp_valid(rsp32_valid), .rsp_rdata(),
		.rsp_fault(rsp32_fault), .rsp_fault_code(rsp32_code), .bus_timeout(bus_timeout),
		.arb_pins(arb_pins), .burst_pin(burst_pin),
		.card_channel_ready_pin(card_channel_ready_pin), .sdr_pins(sdr_pins),
		.ext_irq_pin(ext_irq_pin), .arb_req(arb_req), .arb_level(arb_level),
		.irq_out(), .arb_start(), .slot_reset(),
		.bm_valid(bm_valid), .bm_io(bm_io), .bm_addr(bm_addr), .bm_done(),
		.bm_to_system(), .master_enable(), .mode64(mode32),
		.tce_addr_w0(), .tce_addr_w1());

	// expected configuration word
	function automatic logic [31:0] exp_cfg(input logic me, input logic md);
		return {me, 23'h0, md, CFG_MAX_TCE, CFG_DMA_CHANS};
	endfunction

	// slot_reset[i] follows store bit 16 + i; a stored 0 holds that slot in reset
	function automatic logic [15:0] exp_slot(input logic [31:0] w);
		return ~w[31:16];
	endfunction

	// board identity a probe would read; every third slot is empty and answers all ones
	function automatic logic [15:0] board_id(input int s);
		return (s % 3 == 0) ? 16'hffff : 16'h1000 + 16'(s);
	endfunction

	// 1 MB blocks under 16 MB, one 240 MB block, then 256 MB blocks; i/o space never remaps
	function automatic logic exp_route(input logic [31:0] m, input logic [31:0] ad, input logic io);
		int k;
		if (ad[31:28] != 4'h0)
			k = 16 + ad[31:28];
		else if (ad[27:24] != 4'h0)
			k = 16;
		else
			k = ad[23:20];
		return !io && m[31 - k];
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x)
		begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// set bus pins, let the synchroniser settle, then pulse a timeout
	task automatic timeout_with(input logic [31:0] p);
		@(posedge sys_clk);
		{sdr_pins, card_channel_ready_pin, burst_pin, arb_pins} <= p[7:0];
		repeat (3) @(posedge sys_clk);
		bus_timeout <= 1'b1;
		@(posedge sys_clk);
		bus_timeout <= 1'b0;
		#1;
		`CHK(master_enable, 1'b0);
		`CHK(slot_reset, 16'hffff);
	endtask

	// hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			miscompares++;
			complete_run();
		end
	end

	initial
	begin
		r = $urandom(35933);
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		// startup values
		cpu.xfer(1'b0, IDX_CFG, 1'b1, 32'h0);
		`CHK(cpu.got_data, exp_cfg(1'b0, 1'b1));
		`CHK({mode64, master_enable, arb_start, irq_out}, 4'h8);
		`CHK(mode32, 1'b0);
		`CHK(slot_reset, 16'hffff);
		cpu.xfer(1'b0, IDX_SLOT, 1'b1, 32'h0);
		`CHK(cpu.got_data[31:16], 16'h0);
		$display("test reset done");
		// read-only fields survive a random store, mode bit takes the random bit 7 and is then set again
		r = $urandom() & 32'h7fff_ffff;
		cpu.xfer(1'b1, IDX_CFG, 1'b1, r);
		cpu.xfer(1'b0, IDX_CFG, 1'b1, 32'h0);
		`CHK(cpu.got_data, exp_cfg(1'b0, r[7]));
		`CHK(mode64, r[7]);
		cpu.xfer(1'b1, IDX_CFG, 1'b1, 32'h0000_0080);
		`CHK(mode64, 1'b1);
		`CHK(mode32, 1'b0);
		// table address words go in before master enable
		r = $urandom();
		d = $urandom();
		cpu.xfer(1'b1, IDX_TCE_W0, 1'b1, r);
		cpu.xfer(1'b1, IDX_TCE_W1, 1'b1, d);
		`CHK(tce_addr_w0, r);
		`CHK(tce_addr_w1, d);
		cpu.xfer(1'b1, IDX_CFG, 1'b1, 32'h8000_0080);
		`CHK(master_enable, 1'b1);
		r = $urandom();
		cpu.xfer(1'b1, IDX_PERS, 1'b1, r);
		cpu.xfer(1'b0, IDX_PERS, 1'b1, 32'h0);
		`CHK(cpu.got_data, r & PERS_IMPL_MASK);
		$display("test config done");
		// every arbitration level with enable on, then enable off gates both paths
		ext_irq_pin <= 1'b1;
		arb_req <= 1'b1;
		for (int lv = 0; lv < 16; lv++)
		begin
			@(posedge sys_clk);
			arb_level <= 4'(lv);
			@(posedge sys_clk);
			#1;
			`CHK(arb_start, lv < 15);
		end
		`CHK(irq_out, 1'b1);
		cpu.xfer(1'b1, IDX_CFG, 1'b1, 32'h0000_0080);
		arb_level <= 4'h2;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK({arb_start, irq_out}, 2'b00);
		arb_req <= 1'b0;
		ext_irq_pin <= 1'b0;
		$display("test arbitration done");
		// slot resets held, then released in a random pattern
		cpu.xfer(1'b1, IDX_SLOT, 1'b1, 32'h0);
		repeat (SLOT_HOLD) @(posedge sys_clk);
		r = $urandom();
		cpu.xfer(1'b1, IDX_SLOT, 1'b1, r);
		`CHK(slot_reset, exp_slot(r));
		cpu.xfer(1'b0, IDX_SLOT, 1'b1, 32'h0);
		`CHK(cpu.got_data[31:16], r[31:16]);
		// probe released slots; empty ones answer all ones and go back into reset
		d = r;
		for (int i = 0; i < 16; i++)
			if (board_id(i) == 16'hffff)
				d[31 - i] = 1'b0;
		cpu.xfer(1'b1, IDX_SLOT, 1'b1, d);
		`CHK(slot_reset, exp_slot(d));
		$display("test slots done");
		// bus master routing: range edges first, then random addresses and spaces
		d = $urandom();
		cpu.xfer(1'b1, IDX_MAP, 1'b1, d);
		for (int i = 0; i < 40; i++)
		begin
			a = (i < 6) ? CORNER[i] : $urandom();
			@(posedge sys_clk);
			bm_valid <= 1'b1;
			bm_addr <= a;
			bm_io <= (i < 6) ? 1'b0 : 1'($urandom_range(0, 1));
			@(posedge sys_clk);
			bm_valid <= 1'b0;
			bm_addr <= ~a;
			#1;
			`CHK(bm_done, 1'b1);
			`CHK(bm_to_system, exp_route(d, a, bm_io));
		end
		$display("test mapping done");
		// first timeout is kept until the flag is cleared
		cpu.xfer(1'b1, IDX_CFG, 1'b1, 32'h8000_0080);
		cpu.xfer(1'b1, IDX_SLOT, 1'b1, 32'hffff_0000);
		cpu.xfer(1'b1, IDX_MISC, 1'b1, 32'h0);
		cpu.xfer(1'b0, IDX_SNAP, 1'b1, 32'h0);
		`CHK(cpu.got_data, 32'h0);
		d = $urandom();
		e = ~d;
		timeout_with(d);
		cpu.xfer(1'b1, IDX_SNAP, 1'b1, e);
		cpu.xfer(1'b0, IDX_SNAP, 1'b1, 32'h0);
		`CHK(cpu.got_data, {24'h0, d[7:0]});
		timeout_with(e);
		cpu.xfer(1'b0, IDX_SNAP, 1'b1, 32'h0);
		`CHK(cpu.got_data, {24'h0, d[7:0]});
		cpu.xfer(1'b1, IDX_MISC, 1'b1, 32'h0);
		cpu.xfer(1'b0, IDX_SNAP, 1'b1, 32'h0);
		`CHK(cpu.got_data, 32'h0);
		timeout_with(e);
		cpu.xfer(1'b0, IDX_SNAP, 1'b1, 32'h0);
		`CHK(cpu.got_data, {24'h0, e[7:0]});
		$display("test timeout done");
		// narrow accesses fault with no effect; unmapped places fault too
		cpu.xfer(1'b1, IDX_CFG, 1'b0, 32'h8000_0000);
		`CHK({cpu.got_ok, cpu.got_fault, cpu.got_code}, {2'b11, FAULT_INVALID_OP});
		cpu.xfer(1'b0, IDX_CFG, 1'b1, 32'h0);
		`CHK(cpu.got_fault, 1'b0);
		`CHK(cpu.got_data, exp_cfg(1'b0, 1'b1));
		// word 0 of the table address exists only on the 64-bit part
		cpu.xfer(1'b0, IDX_TCE_W0, 1'b1, 32'h0);
		`CHK(cpu.got_fault, 1'b0);
		`CHK({rsp32_valid, rsp32_fault, rsp32_code}, {2'b11, FAULT_INVALID_OP});
		for (int i = 8; i < 16; i++)
		begin
			cpu.xfer(1'b0, 4'(i), 1'b1, 32'h0);
			`CHK({cpu.got_fault, cpu.got_code}, {1'b1, FAULT_INVALID_OP});
		end
		$display("test faults done");
		complete_run();
	end
endmodule
`default_nettype wire
